// File: common/rtca_pkg.sv
// Package for the alarm, periodic interrupt and supply monitor block.
// Assumes a 100 MHz APB clock and 32-bit APB data with word registers.
package rtca_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_ALARM_W = 4'h0;  // Weekly alarm preset.
  localparam logic [3:0] IDX_ALARM_D = 4'h1;  // Daily alarm preset.
  localparam logic [3:0] IDX_STATUS  = 4'h2;  // Supply monitor state, read only.
  localparam logic [3:0] IDX_CTRL1   = 4'hE;  // Enables and periodic select.
  localparam logic [3:0] IDX_CTRL2   = 4'hF;  // Threshold select and flags.

  // Control register one fields.
  localparam int WEEKLY_EN_BIT = 7;
  localparam int DAILY_EN_BIT  = 6;
  localparam int PSEL_LSB      = 0;
  // Control register two fields.
  localparam int THRESH_BIT    = 7;
  localparam int UNDERV_BIT    = 6;
  localparam int PFLAG_BIT     = 2;
  localparam int WFLAG_BIT     = 1;
  localparam int DFLAG_BIT     = 0;
  // Alarm preset fields: minute, hour and day of week.
  localparam int MIN_LSB  = 0;
  localparam int HOUR_LSB = 8;
  localparam int DOW_LSB  = 16;
  // Status fields.
  localparam int ST_RESET_BIT = 0;
  localparam int ST_MAIN_BIT  = 1;
  localparam int ST_OSC_BIT   = 2;
  localparam int ST_WIN_BIT   = 3;

  // Periodic select codes.
  localparam logic [2:0] PER_OFF    = 3'h0;
  localparam logic [2:0] PER_LOW    = 3'h1;
  localparam logic [2:0] PER_2HZ    = 3'h2;
  localparam logic [2:0] PER_1HZ    = 3'h3;
  localparam logic [2:0] PER_SECOND = 3'h4;
  localparam logic [2:0] PER_MINUTE = 3'h5;
  localparam logic [2:0] PER_HOUR   = 3'h6;
  localparam logic [2:0] PER_MONTH  = 3'h7;

  // Timing: clock period, sampling window and host reset release delay.
  localparam int  CLK_PERIOD_NS  = 10;
  localparam real SAMPLE_TIME_MS = 7.8;
  localparam real TDELAY_MS      = 100.0;
  localparam int  SAMPLE_CYC     = int'($floor(SAMPLE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  TDELAY_CYC     = int'($ceil(TDELAY_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  CNT_W          = 32;

  // Reset value of every register field is zero.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Whole state of the core.
  typedef struct packed {
    logic             main_s1, main_s2;   // Main supply ok synchroniser.
    logic             osc_s1, osc_s2;     // Oscillator running synchroniser.
    logic             bkp_s1, bkp_s2;     // Backup below threshold synchroniser.
    logic             weekly_alarm_enable;
    logic             daily_alarm_enable;
    logic [2:0]       periodic_select;
    logic             backup_threshold_select;
    logic             backup_undervoltage_flag;
    logic             periodic_irq_flag;
    logic             weekly_alarm_flag;
    logic             daily_alarm_flag;
    logic [6:0]       alw_min;
    logic [5:0]       alw_hour;
    logic [2:0]       alw_dow;
    logic [6:0]       ald_min;
    logic [5:0]       ald_hour;
    logic             w_match_prev;
    logic             d_match_prev;
    logic             win_on;
    logic [CNT_W-1:0] win_cnt;
    logic             rst_released;
    logic [CNT_W-1:0] rst_cnt;
    logic             irq_drive;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } rtca_state_type;

endpackage

// File: verilog/rtca_core.sv
// Alarm, periodic interrupt and supply monitor core with an APB register port.
// Assumes the time counters run on pclk and present time plus event pulses;
// the analog detectors are asynchronous and are synchronised here.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// [RQ1] Sample backup detector 7.8 ms each second
// [RQ2] Threshold select: zero high, one low
// [RQ3] Undervoltage flag set stops further sampling
// [RQ4] Undervoltage flag readable at bit six, F
// [RQ5] Host clears undervoltage flag after seconds write
// [RQ6] Release host reset tdelay after supply rise
// [RQ7] Halted oscillator: delay counts from restart
// [RQ8] Supply fall drives host reset low immediately
// [RQ9] Weekly and daily alarms match, drive interrupt
// [RQ10] Flags: weekly bit1, daily bit0, periodic bit2
// [RQ11] Enables: weekly bit7, daily bit6 at E
// [RQ12] Periodic select bits 2..0, zero disables
// [RQ13] Power-on with all disabled: interrupt inactive
// [RQ14] Any active source pulls interrupt low
// [RQ15] Host reads flags to find source
// [RQ16] Alarm flag: write one ignored, zero clears
// [RQ17] Clearing flag keeps enable; alarm re-arms
// [RQ18] Host disables alarm before writing preset
// [RQ19] Re-enable during match does not fire
// [RQ20] Periodic codes: off, low, 2Hz, 1Hz, levels
// [RQ21] Level mode holds low until flag cleared
// [RQ22] Power-on clears control fields and flags
// [RQ23] Detectors pass two flip-flops before use
module rtca_core #(
  parameter int SAMPLE_CYC = rtca_pkg::SAMPLE_CYC,  // Sampling window length in cycles.
  parameter int TDELAY_CYC = rtca_pkg::TDELAY_CYC   // Host reset release delay in cycles.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  time_min,
  input  wire logic [5:0]  time_hour,
  input  wire logic [2:0]  time_dow,
  input  wire logic [1:0]  sub_second_quarter,
  input  wire logic        second_tick,
  input  wire logic        minute_tick,
  input  wire logic        hour_tick,
  input  wire logic        month_tick,
  input  wire logic        main_supply_ok,
  input  wire logic        osc_running,
  input  wire logic        backup_below_thresh,
  output logic             backup_sample_en,
  output logic             backup_threshold_low,
  output logic             host_reset_out_n_o,
  output logic             host_reset_out_n_oe,
  output logic             irq_out_n_o,
  output logic             irq_out_n_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // Both counts must be at least one cycle; the counter width is not checked.
  if (SAMPLE_CYC < 1 || TDELAY_CYC < 1) begin : g_bad_count
    $error("rtca_core: SAMPLE_CYC and TDELAY_CYC must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam logic [rtca_pkg::CNT_W-1:0] SAMPLE_LAST = rtca_pkg::CNT_W'(SAMPLE_CYC - 1);
  localparam logic [rtca_pkg::CNT_W-1:0] TDELAY_LAST = rtca_pkg::CNT_W'(TDELAY_CYC - 1);

  rtca_pkg::rtca_state_type state_ff;   // Registered state.
  rtca_pkg::rtca_state_type nxt_state;  // Next state.

  logic        setup_rd;   // Setup cycle of any transfer.
  logic        acc_wr;     // Write access edge.
  logic        mapped;     // Address hits a register.
  logic [3:0]  idx;        // Register index from the address.
  logic        w_match;    // Weekly preset equals current time.
  logic        d_match;    // Daily preset equals current time.
  logic        w_fire;     // Weekly alarm event.
  logic        d_fire;     // Daily alarm event.
  logic        p_event;    // Periodic level event.
  logic        p_pulse_low; // Pulse mode low phase.
  logic        wr_c2;      // Write to control register two.

  // Returns the readable word of a register index.
  function automatic logic [31:0] read_word(input rtca_pkg::rtca_state_type s,
                                            input logic [3:0] i);
    logic [31:0] w;
    w = rtca_pkg::RESET_WORD;
    case (i)
      rtca_pkg::IDX_ALARM_W: begin
        w[rtca_pkg::MIN_LSB +: 7]  = s.alw_min;
        w[rtca_pkg::HOUR_LSB +: 6] = s.alw_hour;
        w[rtca_pkg::DOW_LSB +: 3]  = s.alw_dow;
      end
      rtca_pkg::IDX_ALARM_D: begin
        w[rtca_pkg::MIN_LSB +: 7]  = s.ald_min;
        w[rtca_pkg::HOUR_LSB +: 6] = s.ald_hour;
      end
      rtca_pkg::IDX_STATUS: begin
        w[rtca_pkg::ST_RESET_BIT] = s.rst_released;
        w[rtca_pkg::ST_MAIN_BIT]  = s.main_s2;
        w[rtca_pkg::ST_OSC_BIT]   = s.osc_s2;
        w[rtca_pkg::ST_WIN_BIT]   = s.win_on;
      end
      rtca_pkg::IDX_CTRL1: begin
        w[rtca_pkg::WEEKLY_EN_BIT]     = s.weekly_alarm_enable;  // RQ11
        w[rtca_pkg::DAILY_EN_BIT]      = s.daily_alarm_enable;
        w[rtca_pkg::PSEL_LSB +: 3]     = s.periodic_select;      // RQ12
      end
      rtca_pkg::IDX_CTRL2: begin
        w[rtca_pkg::THRESH_BIT] = s.backup_threshold_select;
        w[rtca_pkg::UNDERV_BIT] = s.backup_undervoltage_flag;    // RQ4
        w[rtca_pkg::PFLAG_BIT]  = s.periodic_irq_flag;           // RQ10
        w[rtca_pkg::WFLAG_BIT]  = s.weekly_alarm_flag;
        w[rtca_pkg::DFLAG_BIT]  = s.daily_alarm_flag;
      end
      default: w = rtca_pkg::RESET_WORD;
    endcase
    return w;
  endfunction

  // A flag that hardware sets and a write of zero clears; the set wins.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic wr, input logic wbit);
    return set | (cur & ~(wr & ~wbit));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Decodes the bus, updates registers, alarms, periodic logic and monitors.
  always_comb begin
    nxt_state = state_ff;
    idx       = paddr[5:2];
    mapped    = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                (idx == rtca_pkg::IDX_ALARM_W || idx == rtca_pkg::IDX_ALARM_D ||
                 idx == rtca_pkg::IDX_STATUS || idx == rtca_pkg::IDX_CTRL1 ||
                 idx == rtca_pkg::IDX_CTRL2);
    setup_rd  = psel && !penable;
    acc_wr    = psel && penable && state_ff.pready && pwrite && mapped;
    wr_c2     = acc_wr && idx == rtca_pkg::IDX_CTRL2;

    // Detector synchronisers; only the second stage is read.
    nxt_state.main_s1 = main_supply_ok;          // RQ23
    nxt_state.main_s2 = state_ff.main_s1;
    nxt_state.osc_s1  = osc_running;
    nxt_state.osc_s2  = state_ff.osc_s1;
    nxt_state.bkp_s1  = backup_below_thresh;
    nxt_state.bkp_s2  = state_ff.bkp_s1;

    // Bus answer: data and error are prepared in setup, ready one cycle later.
    nxt_state.pready  = setup_rd;
    if (setup_rd) begin
      nxt_state.prdata  = pwrite ? rtca_pkg::RESET_WORD : read_word(state_ff, idx);
      nxt_state.pslverr = !mapped;
    end else if (!psel) begin
      nxt_state.pslverr = 1'b0;
    end

    // Alarm comparators fire on the first cycle of a match while enabled.
    w_match = (time_dow == state_ff.alw_dow) && (time_hour == state_ff.alw_hour) &&
              (time_min == state_ff.alw_min);
    d_match = (time_hour == state_ff.ald_hour) && (time_min == state_ff.ald_min);
    // Matching edges only, so enabling during a held match waits a full cycle of time.
    w_fire  = state_ff.weekly_alarm_enable && w_match && !state_ff.w_match_prev;  // RQ9 RQ19
    d_fire  = state_ff.daily_alarm_enable && d_match && !state_ff.d_match_prev;   // RQ9 RQ19
    nxt_state.w_match_prev = w_match;
    nxt_state.d_match_prev = d_match;

    // Periodic events for the level codes.
    case (state_ff.periodic_select)
      rtca_pkg::PER_SECOND: p_event = second_tick;  // RQ20
      rtca_pkg::PER_MINUTE: p_event = minute_tick;
      rtca_pkg::PER_HOUR:   p_event = hour_tick;
      rtca_pkg::PER_MONTH:  p_event = month_tick;
      default:              p_event = 1'b0;
    endcase

    // Flags: writes of one are ignored, writes of zero clear, events win.
    nxt_state.weekly_alarm_flag = flag_next(state_ff.weekly_alarm_flag, w_fire, wr_c2,
                                            pwdata[rtca_pkg::WFLAG_BIT]);  // RQ10 RQ16 RQ17
    nxt_state.daily_alarm_flag  = flag_next(state_ff.daily_alarm_flag, d_fire, wr_c2,
                                            pwdata[rtca_pkg::DFLAG_BIT]);  // RQ10 RQ16 RQ17
    nxt_state.periodic_irq_flag = flag_next(state_ff.periodic_irq_flag, p_event, wr_c2,
                                            pwdata[rtca_pkg::PFLAG_BIT]);  // RQ10 RQ21

    // Backup sampling window opens on each second unless the flag is set.
    if (state_ff.backup_undervoltage_flag) begin
      nxt_state.win_on  = 1'b0;                                // RQ3
      nxt_state.win_cnt = '0;
    end else if (state_ff.win_on) begin
      nxt_state.win_on  = (state_ff.win_cnt != SAMPLE_LAST);   // RQ1
      nxt_state.win_cnt = state_ff.win_cnt + 1'b1;
    end else if (second_tick) begin
      nxt_state.win_on  = 1'b1;                                // RQ1
      nxt_state.win_cnt = '0;
    end
    nxt_state.backup_undervoltage_flag =
      flag_next(state_ff.backup_undervoltage_flag, state_ff.win_on && state_ff.bkp_s2,
                wr_c2, pwdata[rtca_pkg::UNDERV_BIT]);          // RQ1 RQ5

    // Host reset: low at once on supply loss, released after the delay.
    if (!state_ff.main_s2) begin
      nxt_state.rst_released = 1'b0;                           // RQ8
      nxt_state.rst_cnt      = '0;
    end else if (!state_ff.rst_released) begin
      if (!state_ff.osc_s2) begin
        nxt_state.rst_cnt = '0;                                // RQ7
      end else if (state_ff.rst_cnt == TDELAY_LAST) begin
        nxt_state.rst_released = 1'b1;                         // RQ6
      end else begin
        nxt_state.rst_cnt = state_ff.rst_cnt + 1'b1;           // RQ6
      end
    end

    // Register writes.
    if (acc_wr) begin
      case (idx)
        rtca_pkg::IDX_ALARM_W: begin
          nxt_state.alw_min  = pwdata[rtca_pkg::MIN_LSB +: 7];
          nxt_state.alw_hour = pwdata[rtca_pkg::HOUR_LSB +: 6];
          nxt_state.alw_dow  = pwdata[rtca_pkg::DOW_LSB +: 3];
        end
        rtca_pkg::IDX_ALARM_D: begin
          nxt_state.ald_min  = pwdata[rtca_pkg::MIN_LSB +: 7];
          nxt_state.ald_hour = pwdata[rtca_pkg::HOUR_LSB +: 6];
        end
        rtca_pkg::IDX_CTRL1: begin
          nxt_state.weekly_alarm_enable = pwdata[rtca_pkg::WEEKLY_EN_BIT];  // RQ11
          nxt_state.daily_alarm_enable  = pwdata[rtca_pkg::DAILY_EN_BIT];   // RQ11
          nxt_state.periodic_select     = pwdata[rtca_pkg::PSEL_LSB +: 3];  // RQ12
        end
        rtca_pkg::IDX_CTRL2: begin
          nxt_state.backup_threshold_select = pwdata[rtca_pkg::THRESH_BIT];  // RQ2
        end
        default: begin
          nxt_state.pslverr = state_ff.pslverr;
        end
      endcase
    end

    // Pulse phase follows the select being written, so switching off leaves no stale low.
    case (nxt_state.periodic_select)
      rtca_pkg::PER_2HZ: p_pulse_low = !sub_second_quarter[0];  // RQ20
      rtca_pkg::PER_1HZ: p_pulse_low = !sub_second_quarter[1];
      default:           p_pulse_low = 1'b0;
    endcase

    // Shared interrupt: any active source pulls the line low.
    nxt_state.irq_drive =
      nxt_state.weekly_alarm_flag || nxt_state.daily_alarm_flag ||        // RQ14 RQ16
      (nxt_state.periodic_select == rtca_pkg::PER_LOW) || p_pulse_low ||  // RQ20
      (nxt_state.periodic_select[2] && nxt_state.periodic_irq_flag);      // RQ21 RQ13
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Power-on reset clears every field, so all enables and flags start at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;  // RQ22 RQ13
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  assign prdata               = state_ff.prdata;
  assign pready               = state_ff.pready;
  assign pslverr              = state_ff.pslverr;
  assign backup_sample_en     = state_ff.win_on;
  assign backup_threshold_low = state_ff.backup_threshold_select;  // RQ2
  // Open-drain pins only ever pull low, so the data bit is the reset value.
  assign host_reset_out_n_o   = state_ff.prdata[31] & 1'b0;
  assign host_reset_out_n_oe  = !state_ff.rst_released;
  assign irq_out_n_o          = state_ff.prdata[31] & 1'b0;
  assign irq_out_n_oe         = state_ff.irq_drive;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_window_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_ff.win_on) |-> state_ff.win_on [*2];
  endproperty
  a_window_len: assert property (p_window_len) else $error("window closed early");  // RQ1

  property p_no_window_flagged;
    @(posedge pclk) disable iff (!presetn)
    state_ff.backup_undervoltage_flag && !wr_c2 |=> !state_ff.win_on;
  endproperty
  a_no_window_flagged: assert property (p_no_window_flagged)
    else $error("sampling while flag set");  // RQ3

  property p_thresh_out;
    @(posedge pclk) disable iff (!presetn)
    wr_c2 |=> backup_threshold_low == $past(pwdata[rtca_pkg::THRESH_BIT]);
  endproperty
  a_thresh_out: assert property (p_thresh_out) else $error("threshold output wrong");  // RQ2

  property p_reset_fall;
    @(posedge pclk) disable iff (!presetn)
    !state_ff.main_s2 |=> host_reset_out_n_oe;
  endproperty
  a_reset_fall: assert property (p_reset_fall) else $error("host reset not driven");  // RQ8

  property p_reset_release;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_ff.rst_released) |->
      $past(state_ff.main_s2) && $past(state_ff.osc_s2) && $past(state_ff.rst_cnt) == TDELAY_LAST;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("early reset release");  // RQ6

  property p_osc_restart;
    @(posedge pclk) disable iff (!presetn)
    state_ff.main_s2 && !state_ff.osc_s2 && !state_ff.rst_released |=> state_ff.rst_cnt == '0;
  endproperty
  a_osc_restart: assert property (p_osc_restart) else $error("delay not restarted");  // RQ7

  property p_alarm_irq;
    @(posedge pclk) disable iff (!presetn)
    w_fire || d_fire |=> irq_out_n_oe && (state_ff.weekly_alarm_flag || state_ff.daily_alarm_flag);
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm did not drive line");  // RQ9

  property p_no_refire;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_ff.daily_alarm_enable) && d_match && $past(d_match) &&
    !state_ff.daily_alarm_flag |=> !state_ff.daily_alarm_flag;
  endproperty
  a_no_refire: assert property (p_no_refire) else $error("fired on re-enable");  // RQ19

  property p_idle_high;
    @(posedge pclk) disable iff (!presetn)
    !state_ff.weekly_alarm_flag && !state_ff.daily_alarm_flag &&
    state_ff.periodic_select == rtca_pkg::PER_OFF |-> !irq_out_n_oe;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low with no source");  // RQ13

  property p_level_hold;
    @(posedge pclk) disable iff (!presetn)
    state_ff.periodic_irq_flag && state_ff.periodic_select[2] && !acc_wr
      |=> irq_out_n_oe && state_ff.periodic_irq_flag;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level released early");  // RQ21

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_c2 && !pwdata[rtca_pkg::DFLAG_BIT] && !d_fire |=> !state_ff.daily_alarm_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");  // RQ16

endmodule

`default_nettype wire

// File: bench/rtca_host_model.sv
// Host side model: pull-up resistors on the two open-drain lines of the core.
// Assumes the core drives each line only low, through its output enable.
`timescale 1ns/1ns
`default_nettype none

module rtca_host_model (
  input  wire logic irq_oe,
  input  wire logic rst_oe,
  output logic      irq_line,
  output logic      rst_line
);
  // A released line floats up to the pull-up level, never holds a stale low.
  assign irq_line = irq_oe ? 1'b0 : 1'b1;
  assign rst_line = rst_oe ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// File: bench/test_rtca_core.sv
// Self-checking bench for the alarm, periodic and supply monitor core.
// Assumes short counts: an 8-cycle sampling window and a 16-cycle release delay.
`timescale 1ns/1ns
`default_nettype none

module test_rtca_core;
  logic        pclk = 1'b0;             // APB clock, 100 MHz.
  logic        presetn = 1'b0;          // Asynchronous reset, active low.
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, perr;   // Slave answer and captured error.
  logic [6:0]  tmin = 7'h00;            // Current time from the counters.
  logic [5:0]  thour = 6'h00;
  logic [2:0]  tdow = 3'h0;
  logic [1:0]  quarter = 2'h0;          // Quarter of the second.
  logic [3:0]  tk = 4'h0;               // Second, minute, hour, month ticks.
  logic        main_ok = 1'b1, osc = 1'b1, below = 1'b0;
  logic        smp_en, thr_low, rst_o, rst_oe, irq_o, irq_oe, irq_line, rst_line;
  int          n_errors = 0, cmp_count = 0;

  always #5 pclk = ~pclk;

  rtca_core #(.SAMPLE_CYC(8), .TDELAY_CYC(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_min(tmin), .time_hour(thour), .time_dow(tdow), .sub_second_quarter(quarter),
    .second_tick(tk[0]), .minute_tick(tk[1]), .hour_tick(tk[2]), .month_tick(tk[3]),
    .main_supply_ok(main_ok), .osc_running(osc), .backup_below_thresh(below),
    .backup_sample_en(smp_en), .backup_threshold_low(thr_low),
    .host_reset_out_n_o(rst_o), .host_reset_out_n_oe(rst_oe),
    .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe));

  rtca_host_model host_u (.irq_oe(irq_oe), .rst_oe(rst_oe), .irq_line(irq_line),
    .rst_line(rst_line));

  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic w, input logic [3:0] i, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'h0, i, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Compares one result and reports a difference at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask

  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 32'h0, r);
    chk(r, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // A one-cycle event pulse from the time counters.
  task automatic tick(input int b);
    @(posedge pclk);
    tk[b] <= 1'b1;
    @(posedge pclk);
    tk[b] <= 1'b0;
  endtask

  task automatic summarize;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 5000 cycles.
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [31:0] r;
    cyc(3);
    presetn <= 1'b1;
    cyc(12); chk(rst_line, 0);
    cyc(20); chk(rst_line, 1);
    main_ok <= 1'b0;
    cyc(5); chk(rst_line, 0);
    osc <= 1'b0; main_ok <= 1'b1;
    cyc(30); chk(rst_line, 0);
    osc <= 1'b1;
    cyc(12); chk(rst_line, 0);
    cyc(20); chk(rst_line, 1);
    rd(rtca_pkg::IDX_CTRL1, 32'h0);
    rd(rtca_pkg::IDX_CTRL2, 32'h0);
    chk(irq_line, 1);
    chk({irq_o, rst_o}, 0);
    // An unmapped index is refused with an error and reads zero.
    xfer(1'b0, 4'h5, 32'h0, r); chk(r, 0); chk(perr, 1);
    // Daily alarm at 05:30, programmed with the enable off.
    wr(rtca_pkg::IDX_ALARM_D, 32'h0000_051E);
    wr(rtca_pkg::IDX_CTRL1, 32'h40);
    thour <= 6'h05; tmin <= 7'h1E;
    cyc(3); chk(irq_line, 0);
    rd(rtca_pkg::IDX_CTRL2, 32'h1);
    wr(rtca_pkg::IDX_CTRL2, 32'h7);
    rd(rtca_pkg::IDX_CTRL2, 32'h1);
    wr(rtca_pkg::IDX_CTRL2, 32'h0);
    cyc(2); chk(irq_line, 1);
    rd(rtca_pkg::IDX_CTRL1, 32'h40);
    tmin <= 7'h1F; cyc(2); tmin <= 7'h1E;
    cyc(3); chk(irq_line, 0);
    wr(rtca_pkg::IDX_CTRL2, 32'h0);
    // Re-enabling while the time already matches must stay quiet.
    wr(rtca_pkg::IDX_CTRL1, 32'h0);
    wr(rtca_pkg::IDX_CTRL1, 32'h40);
    cyc(3); chk(irq_line, 1);
    // Weekly alarm: day of week must match too.
    wr(rtca_pkg::IDX_CTRL1, 32'h0);
    tdow <= 3'h2;
    wr(rtca_pkg::IDX_ALARM_W, 32'h0003_051E);
    wr(rtca_pkg::IDX_CTRL1, 32'h80);
    tmin <= 7'h1F; cyc(2); tmin <= 7'h1E;
    cyc(3); chk(irq_line, 1);
    tdow <= 3'h3;
    cyc(3); chk(irq_line, 0);
    rd(rtca_pkg::IDX_CTRL2, 32'h2);
    // Fixed low joins the weekly source; clearing one source must keep the line low.
    wr(rtca_pkg::IDX_CTRL1, 32'h81);
    wr(rtca_pkg::IDX_CTRL2, 32'h0);
    cyc(2); chk(irq_line, 0);
    // Level modes: second, minute, hour and month events.
    for (int k = 0; k < 4; k++) begin
      wr(rtca_pkg::IDX_CTRL1, 32'(4 + k));
      tick(k);
      cyc(4); chk(irq_line, 0);
      rd(rtca_pkg::IDX_CTRL2, 32'h4);
      wr(rtca_pkg::IDX_CTRL2, 32'h0);
      cyc(2); chk(irq_line, 1);
    end
    // Pulse modes: 2 Hz low in even quarters, 1 Hz low in the first half.
    for (int c = 2; c < 4; c++) begin
      wr(rtca_pkg::IDX_CTRL1, 32'(c));
      for (int q = 0; q < 4; q++) begin
        quarter <= 2'(q);
        cyc(3); chk(irq_line, (c == 2) ? q % 2 : q / 2);
      end
    end
    wr(rtca_pkg::IDX_CTRL1, 32'h0);
    // Backup monitor: threshold select, window length, sticky flag.
    wr(rtca_pkg::IDX_CTRL2, 32'h80);
    cyc(2); chk(thr_low, 1);
    wr(rtca_pkg::IDX_CTRL2, 32'h0);
    cyc(2); chk(thr_low, 0);
    tick(0);
    cyc(8); chk(smp_en, 1);
    cyc(1); chk(smp_en, 0);
    below <= 1'b1;
    tick(0);
    cyc(12); rd(rtca_pkg::IDX_CTRL2, 32'h40);
    below <= 1'b0;
    tick(0);
    cyc(2); chk(smp_en, 0);
    wr(rtca_pkg::IDX_CTRL2, 32'h0);
    rd(rtca_pkg::IDX_CTRL2, 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
